// ===== src/tio_io_control.sv
// Overview of operation
// R1: End of keyboard strobe sets transmit-pending when online.
// R2: Trailing edge of transmit-accepted pulse clears transmit-pending.
// R3: Offline holds transmit-pending cleared regardless of strobes.
// R4: Compose online holds transmit-pending clear until send button pulse.
// R5: Receive-ready only while online, tab idle, no page full, no erase.
// R6: Receive-ready set on online select, end of home, aux-done, function-done.
// R7: Leading edge of host byte strobe clears receive-ready until the next rearm.
// R8: Keyboard strobe in compose clears receive-ready.
// R9: Power-up init clears slant latch; function-done leaves slant off.
// R10: Link error in text mode asserts slant; function-done removes it after.
// R11: Slant command latches slant on; only unit separator or power-up init releases it.
// R12: Init deasserts large-glyph; glyph command latches it asserted low.
// R13: Large glyph also doubles line and character spacing.
// R14: Large glyph with glyph in progress drives bright beam low.
// R15: Large glyph with text mode low drives bright beam for graphics.
// R16: Input strobes captured before one tick give exactly one control or accessory strobe.
// R17: Captured strobe gives one 1 MHz period pulse; capture clears as the pulse starts.
// R18: Home pulse clears strobe select, routing to control-input strobe.
// R19: Graphics write active with printer busy or accessory graphics selects accessory.
// R20: Entering plot or vector mode drives text low and graphics high.
// R21: Asynchronous inputs pass two flops and registered edge detectors.
// R22: Host strobes only while ready; accepted pulse only after taking data.
`timescale 1ns/1ns
`include "tio_defines.svh"
module tio_io_control
    import tio_pkg::*;
#(
    parameter int DIV = `TIO_TICK_DIV
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // AXI4-Lite write
    input  wire logic [`TIO_AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read
    input  wire logic [`TIO_AXI_AW-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Keyboard and host link
    input  wire logic                   keyboard_data_strobe,
    input  wire logic                   host_byte_strobe,
    input  wire logic                   tx_taken_n,
    input  wire logic                   send_button_pulse_n,
    input  wire logic                   online_select,
    output logic                        tx_pending,
    output logic                        host_accept_ready,
    // Receive gating
    input  wire logic                   tab_busy,
    input  wire logic                   page_full,
    input  wire logic                   erase_interval,
    input  wire logic                   home_n,
    input  wire logic                   aux_done_n,
    input  wire logic                   function_done,
    // Character attributes
    input  wire logic                   power_up_init,
    input  wire logic                   slant_command,
    input  wire logic                   unit_separator,
    input  wire logic                   link_error_n,
    input  wire logic                   large_glyph_command,
    input  wire logic                   glyph_in_progress_n,
    input  wire logic                   graphics_entry,
    output logic                        slant_out,
    output logic                        large_glyph_n,
    output logic                        double_spacing,
    output logic                        bright_beam_n,
    output logic                        text_mode_flag,
    output logic                        graphics_flag,
    // Strobe steering
    input  wire logic                   graphics_write_active_n,
    input  wire logic                   printer_busy_flag_n,
    input  wire logic                   accessory_graphics_n,
    output logic                        control_input_strobe,
    output logic                        accessory_input_strobe
);

    localparam int NP = PIN_COUNT;

    // Idle level of every pin, so no edge is seen as reset lifts
    localparam logic [NP-1:0] PIN_IDLE = NP'((1 << PIN_TX_TAKEN_N) | (1 << PIN_SEND_N) |
        (1 << PIN_HOME_N) | (1 << PIN_AUX_DONE_N) | (1 << PIN_LINK_ERR_N) |
        (1 << PIN_GLYPH_PROG_N) | (1 << PIN_GWA_N) | (1 << PIN_PRN_BUSY_N) |
        (1 << PIN_ACC_GRAPH_N));

    localparam tio_state_s RST = '{text: 1'b1, bright_n: 1'b1, default: '0};

    initial begin
        if (DIV < 2 || DIV > `TIO_DIV_MAX) $error("DIV must lie in 2..256");
    end

    tio_state_s      q;
    tio_state_s      d;
    logic [NP-1:0]   raw;
    logic [NP-1:0]   lvl;
    logic [NP-1:0]   rise;
    logic [NP-1:0]   fall;
    tio_word_t       status;

    // Bit order follows the pin index enum, highest index first
    assign raw = {power_up_init, accessory_graphics_n, printer_busy_flag_n,
                  graphics_write_active_n, graphics_entry, glyph_in_progress_n,
                  large_glyph_command, link_error_n, unit_separator, slant_command,
                  host_byte_strobe, function_done, aux_done_n, home_n, erase_interval,
                  page_full, tab_busy, online_select, send_button_pulse_n, tx_taken_n,
                  keyboard_data_strobe};

    tio_pin_sync #(
        .N    (NP),
        .IDLE (PIN_IDLE)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pins    (raw),
        .lvl     (lvl),
        .rise    (rise),
        .fall    (fall)
    ); // R21

    function automatic tio_reg_e decode(input logic [3:0] a);
        case (a)
            `TIO_CTRL_OFS: decode = REG_CTRL;
            `TIO_STAT_OFS: decode = REG_STAT;
            default:       decode = REG_NONE;
        endcase
    endfunction

    // J/K of the strobe-select flip-flop
    function automatic logic jk_next(input logic cur, input logic j, input logic k);
        case ({j, k})
            2'b10:   jk_next = 1'b1;
            2'b01:   jk_next = 1'b0;
            2'b11:   jk_next = ~cur;
            default: jk_next = cur;
        endcase
    endfunction

    always_comb begin
        status                      = '0;
        status[`TIO_STAT_TX_PEND]   = q.tx_pend;
        status[`TIO_STAT_RX_RDY]    = q.rx_rdy;
        status[`TIO_STAT_SLANT]     = q.slant_ff;
        status[`TIO_STAT_GLYPH]     = q.glyph;
        status[`TIO_STAT_TEXT]      = q.text;
        status[`TIO_STAT_SELECT]    = q.select;
        status[`TIO_STAT_SLANT_LAT] = q.slant_latch;
        status[`TIO_STAT_ONLINE]    = lvl[PIN_ONLINE];
    end

    always_comb begin
        logic online;
        logic hold_tx;
        logic rx_ok;
        logic rearm;
        logic err_on;
        logic init;
        logic sel;
        online  = lvl[PIN_ONLINE];
        init    = lvl[PIN_INIT];
        sel     = q.select;
        hold_tx = ~online | (q.compose & ~q.send_seen); // R3 R4
        rx_ok   = online & ~lvl[PIN_TAB_BUSY] & ~lvl[PIN_PAGE_FULL] & ~lvl[PIN_ERASE]; // R5
        rearm   = rise[PIN_ONLINE] | rise[PIN_HOME_N] | rise[PIN_AUX_DONE_N] |
                  fall[PIN_FUNC_DONE]; // R6
        err_on  = q.text & ~lvl[PIN_LINK_ERR_N];
        d       = q;
        // 1 MHz timebase as a one-cycle enable
        d.tick = 1'b0;
        if (q.div == 8'(DIV - 1)) begin
            d.div  = '0;
            d.tick = 1'b1;
        end else begin
            d.div = q.div + 8'h01;
        end
        // Strobe pulse spans one full tick period
        if (q.tick) begin
            d.ctl = 1'b0;
            d.aux = 1'b0;
            if (q.cap) begin
                sel = jk_next(q.select, ~lvl[PIN_PRN_BUSY_N] | ~lvl[PIN_ACC_GRAPH_N],
                              lvl[PIN_GWA_N]); // R19
                d.select = sel;
                d.ctl    = ~sel; // R16
                d.aux    = sel; // R16
                d.cap    = 1'b0; // R17
            end
        end
        // A strobe landing on the consuming tick is kept for the next one
        if (rise[PIN_KBD_STROBE] || rise[PIN_HOST_STROBE]) d.cap = 1'b1; // R17
        if (fall[PIN_HOME_N]) d.select = 1'b0; // R18
        // Transmit pending: set beats accepted-clear, the hold beats both
        d.send_seen = q.compose & (q.send_seen | fall[PIN_SEND_N]); // R4
        if (rise[PIN_TX_TAKEN_N]) d.tx_pend = 1'b0; // R2
        if (fall[PIN_KBD_STROBE] && online) d.tx_pend = 1'b1; // R1
        if (hold_tx) d.tx_pend = 1'b0; // R3 R4
        // Receive ready: a rearm beats a strobe clear in the same cycle; offline beats both
        if (rise[PIN_HOST_STROBE]) d.rx_arm = 1'b0; // R7
        if (q.compose && rise[PIN_KBD_STROBE]) d.rx_arm = 1'b0; // R8
        if (rearm) d.rx_arm = 1'b1; // R6
        if (!online) d.rx_arm = 1'b0;
        d.rx_rdy = d.rx_arm & rx_ok; // R5
        // Text and graphics modes; graphics entry wins
        if (rise[PIN_UNIT_SEP]) d.text = 1'b1;
        if (rise[PIN_GRAPH_ENTRY]) d.text = 1'b0; // R20
        // Slant
        if (rise[PIN_UNIT_SEP]) d.slant_latch = 1'b0; // R11
        if (rise[PIN_SLANT_CMD]) d.slant_latch = 1'b1; // R11
        if (rise[PIN_FUNC_DONE] && !err_on && !q.slant_latch) d.slant_ff = 1'b0; // R9 R10 R11
        if (err_on || q.slant_latch) d.slant_ff = 1'b1; // R10 R11
        // Large glyph; init clears the attribute latches while it stands
        if (rise[PIN_GLYPH_CMD]) d.glyph = 1'b1; // R12
        if (init) begin
            d.slant_latch = 1'b0; // R9
            d.slant_ff    = 1'b0; // R9
            d.glyph       = 1'b0; // R12
        end
        d.bright_n = ~(d.glyph & (~lvl[PIN_GLYPH_PROG_N] | ~d.text)); // R14 R15
        // Register writes
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_got = 1'b1;
            d.waddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_got  = 1'b1;
            d.wdata0 = s_axi_wdata[`TIO_CTRL_COMPOSE];
            d.wstrb0 = s_axi_wstrb[0];
        end
        if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `TIO_RESP_OKAY;
            case (decode(q.waddr))
                REG_CTRL: d.compose = q.wstrb0 ? q.wdata0 : q.compose;
                REG_STAT: d.bresp = `TIO_RESP_OKAY;
                default:  d.bresp = `TIO_RESP_SLVERR;
            endcase
        end
        // Register reads
        if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `TIO_RESP_OKAY;
            case (decode(s_axi_araddr))
                REG_CTRL: d.rdata = {31'h0, q.compose};
                REG_STAT: d.rdata = status;
                default: begin
                    d.rdata = '0;
                    d.rresp = `TIO_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready          = ~q.aw_got & ~q.bvalid;
    assign s_axi_wready           = ~q.w_got & ~q.bvalid;
    assign s_axi_bvalid           = q.bvalid;
    assign s_axi_bresp            = q.bresp;
    assign s_axi_arready          = ~q.rvalid;
    assign s_axi_rvalid           = q.rvalid;
    assign s_axi_rdata            = q.rdata;
    assign s_axi_rresp            = q.rresp;
    assign tx_pending             = q.tx_pend;
    assign host_accept_ready      = q.rx_rdy;
    assign slant_out              = q.slant_ff;
    assign large_glyph_n          = ~q.glyph;
    assign double_spacing         = q.glyph; // R13
    assign bright_beam_n          = q.bright_n;
    assign text_mode_flag         = q.text;
    assign graphics_flag          = ~q.text; // R20
    assign control_input_strobe   = q.ctl;
    assign accessory_input_strobe = q.aux;

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_captured;
        $rose(q.cap);
    endsequence

    sequence s_pulse_start;
        ##[1:256] (q.ctl || q.aux);
    endsequence

    property p_tx_set;
        (fall[PIN_KBD_STROBE] && lvl[PIN_ONLINE] && !q.compose) |=> tx_pending;
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("pending not set"); // R1

    property p_tx_clear;
        (rise[PIN_TX_TAKEN_N] && !fall[PIN_KBD_STROBE]) |=> !tx_pending;
    endproperty
    a_tx_clear: assert property (p_tx_clear) else $error("pending not cleared"); // R2

    property p_tx_offline;
        !lvl[PIN_ONLINE] |=> !tx_pending;
    endproperty
    a_tx_offline: assert property (p_tx_offline) else $error("pending while offline"); // R3

    property p_rx_gate;
        host_accept_ready |-> $past(lvl[PIN_ONLINE]) && !$past(lvl[PIN_ERASE]) &&
            !$past(lvl[PIN_TAB_BUSY]) && !$past(lvl[PIN_PAGE_FULL]);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("ready without conditions"); // R5

    property p_rx_host;
        (rise[PIN_HOST_STROBE] && !rise[PIN_HOME_N] && !rise[PIN_AUX_DONE_N] &&
            !fall[PIN_FUNC_DONE] && !rise[PIN_ONLINE]) |=> !host_accept_ready;
    endproperty
    a_rx_host: assert property (p_rx_host) else $error("ready kept on host strobe"); // R7

    property p_glyph;
        (rise[PIN_GLYPH_CMD] && !lvl[PIN_INIT]) |=> !large_glyph_n && double_spacing;
    endproperty
    a_glyph: assert property (p_glyph) else $error("glyph not latched"); // R12

    property p_bright_gfx;
        (q.glyph && !q.text && !lvl[PIN_INIT] && !rise[PIN_UNIT_SEP]) |=> !bright_beam_n;
    endproperty
    a_bright_gfx: assert property (p_bright_gfx) else $error("graphics beam not bright"); // R15

    property p_bright_low;
        (q.glyph && !lvl[PIN_GLYPH_PROG_N] && !lvl[PIN_INIT]) |=> !bright_beam_n;
    endproperty
    a_bright_low: assert property (p_bright_low) else $error("beam not bright"); // R14

    property p_one_route;
        !(control_input_strobe && accessory_input_strobe);
    endproperty
    a_one_route: assert property (p_one_route) else $error("both strobes high"); // R16

    property p_pulse_follows;
        s_captured |-> s_pulse_start;
    endproperty
    a_pulse_follows: assert property (p_pulse_follows) else $error("no strobe pulse"); // R17

    property p_pulse_ends;
        $fell(q.ctl || q.aux) |-> $past(q.tick);
    endproperty
    a_pulse_ends: assert property (p_pulse_ends) else $error("pulse not tick aligned"); // R17

    property p_home_select;
        (fall[PIN_HOME_N] && !(q.tick && q.cap)) |=> !q.select;
    endproperty
    a_home_select: assert property (p_home_select) else $error("select not cleared"); // R18

    property p_graph_entry;
        rise[PIN_GRAPH_ENTRY] |=> !text_mode_flag && graphics_flag;
    endproperty
    a_graph_entry: assert property (p_graph_entry) else $error("text flag kept"); // R20

endmodule

// ===== src/tio_defines.svh
`ifndef TIO_DEFINES_SVH
`define TIO_DEFINES_SVH

// Clock rates
`define TIO_CLK_HZ          20000000
`define TIO_TICK_HZ         1000000
`define TIO_TICK_DIV        (`TIO_CLK_HZ / `TIO_TICK_HZ)
`define TIO_DIV_MAX         256

// Register map (byte addresses)
`define TIO_AXI_AW          4
`define TIO_CTRL_OFS        4'h0
`define TIO_STAT_OFS        4'h4

// Control register fields
`define TIO_CTRL_COMPOSE    0
`define TIO_CTRL_RESET      32'h0000_0000

// Status register fields
`define TIO_STAT_TX_PEND    0
`define TIO_STAT_RX_RDY     1
`define TIO_STAT_SLANT      2
`define TIO_STAT_GLYPH      3
`define TIO_STAT_TEXT       4
`define TIO_STAT_SELECT     5
`define TIO_STAT_SLANT_LAT  6
`define TIO_STAT_ONLINE     7

// AXI responses
`define TIO_RESP_OKAY       2'b00
`define TIO_RESP_SLVERR     2'b10

`endif

// ===== src/tio_pkg.sv
package tio_pkg;

    // Index of each asynchronous input in the synchroniser vector
    typedef enum {
        PIN_KBD_STROBE,
        PIN_TX_TAKEN_N,
        PIN_SEND_N,
        PIN_ONLINE,
        PIN_TAB_BUSY,
        PIN_PAGE_FULL,
        PIN_ERASE,
        PIN_HOME_N,
        PIN_AUX_DONE_N,
        PIN_FUNC_DONE,
        PIN_HOST_STROBE,
        PIN_SLANT_CMD,
        PIN_UNIT_SEP,
        PIN_LINK_ERR_N,
        PIN_GLYPH_CMD,
        PIN_GLYPH_PROG_N,
        PIN_GRAPH_ENTRY,
        PIN_GWA_N,
        PIN_PRN_BUSY_N,
        PIN_ACC_GRAPH_N,
        PIN_INIT,
        PIN_COUNT
    } tio_pin_e;

    typedef enum {
        REG_CTRL,
        REG_STAT,
        REG_NONE
    } tio_reg_e;

    typedef logic [31:0] tio_word_t;

    typedef struct packed {
        logic [7:0]  div;
        logic        tick;
        logic        cap;
        logic        select;
        logic        ctl;
        logic        aux;
        logic        compose;
        logic        send_seen;
        logic        tx_pend;
        logic        rx_arm;
        logic        rx_rdy;
        logic        slant_latch;
        logic        slant_ff;
        logic        glyph;
        logic        bright_n;
        logic        text;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  waddr;
        logic        wdata0;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        tio_word_t   rdata;
    } tio_state_s;

endpackage

// ===== src/tio_pin_sync.sv
`timescale 1ns/1ns
module tio_pin_sync
    import tio_pkg::*;
#(
    parameter int          N    = 1,
    parameter logic [N-1:0] IDLE = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Raw asynchronous levels
    input  wire logic [N-1:0] pins,
    // Synchronised level and registered edges
    output logic [N-1:0]      lvl,
    output logic [N-1:0]      rise,
    output logic [N-1:0]      fall
);

    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
        logic [N-1:0] s3;
    } tio_sync_s;

    tio_sync_s q;
    tio_sync_s d;

    initial begin
        if (N < 1) $error("tio_pin_sync needs at least one input");
    end

    // Only s2 and s3 are looked at; s1 may be metastable
    always_comb begin
        d    = q;
        d.s1 = pins;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= {IDLE, IDLE, IDLE};
        end else begin
            q <= d;
        end
    end

    assign lvl  = q.s2;
    assign rise = q.s2 & ~q.s3;
    assign fall = ~q.s2 & q.s3;

endmodule

// ===== verif/tio_host_model.sv
`timescale 1ns/1ns
module tio_host_model (
    // Clock
    input  wire logic       clk,
    // Requests from the bench
    input  wire logic       kbd_req,
    input  wire logic       host_req,
    input  wire logic       take,
    input  wire logic [2:0] lag,
    // Terminal side
    input  wire logic       tx_pending,
    input  wire logic       host_accept_ready,
    output logic            keyboard_data_strobe,
    output logic            host_byte_strobe,
    output logic            tx_taken_n
);
    initial begin
        keyboard_data_strobe = 1'b0;
        host_byte_strobe = 1'b0;
        tx_taken_n = 1'b1;
    end
    always @(posedge clk) if (kbd_req) begin
        keyboard_data_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        keyboard_data_strobe <= 1'b0;
    end
    // A byte is only offered once the terminal says it can take it
    always @(posedge clk) if (host_req) begin
        while (!host_accept_ready) @(posedge clk);
        host_byte_strobe <= 1'b1;
        repeat (3) @(posedge clk);
        host_byte_strobe <= 1'b0;
    end
    always @(posedge clk) if (tx_pending && take) begin
        repeat (lag) @(posedge clk);
        tx_taken_n <= 1'b0;
        repeat (3) @(posedge clk);
        tx_taken_n <= 1'b1;
        repeat (6) @(posedge clk);
    end
endmodule

// ===== verif/tb_terminal_io_handshake_control.sv
`timescale 1ns/1ns
module tb_terminal_io_handshake_control;
    import tio_pkg::*;
    localparam int DIV = 4;
    logic        clk, reset_n, online_select, power_up_init, link_error_n, tx_pending;
    logic        tab_busy, page_full, erase_interval, glyph_in_progress_n, sel;
    logic        graphics_write_active_n, printer_busy_flag_n, accessory_graphics_n;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        keyboard_data_strobe, host_byte_strobe, tx_taken_n, large_glyph_n;
    logic        host_accept_ready, slant_out, double_spacing, bright_beam_n, graphics_flag;
    logic        text_mode_flag, control_input_strobe, accessory_input_strobe;
    logic        kbd_req, host_req, take, cs_q, as_q;
    logic [2:0]  lag;
    logic [7:0]  p;
    int          mismatches, n_tests, n_ctl, n_aux, exp_ctl, exp_aux, run, wbad;
    int          src [3] = '{6, 0, 5};

    tio_io_control #(.DIV(DIV)) u_dut (
        .clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .keyboard_data_strobe,
        .host_byte_strobe, .tx_taken_n, .send_button_pulse_n(~p[7]), .online_select,
        .tx_pending, .host_accept_ready, .tab_busy, .page_full, .erase_interval,
        .home_n(~p[5]), .aux_done_n(~p[6]), .function_done(p[0]), .power_up_init,
        .slant_command(p[1]), .unit_separator(p[2]), .link_error_n,
        .large_glyph_command(p[3]), .glyph_in_progress_n, .graphics_entry(p[4]),
        .slant_out, .large_glyph_n, .double_spacing, .bright_beam_n, .text_mode_flag,
        .graphics_flag, .graphics_write_active_n, .printer_busy_flag_n,
        .accessory_graphics_n, .control_input_strobe, .accessory_input_strobe
    );
    tio_host_model u_far (.clk, .kbd_req, .host_req, .take, .lag, .tx_pending,
        .host_accept_ready, .keyboard_data_strobe, .host_byte_strobe, .tx_taken_n);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cs_q <= control_input_strobe;
        as_q <= accessory_input_strobe;
        if (control_input_strobe && !cs_q) n_ctl <= n_ctl + 1;
        if (accessory_input_strobe && !as_q) n_aux <= n_aux + 1;
        if (control_input_strobe || accessory_input_strobe) run <= run + 1;
        else begin
            if (run != 0 && run != DIV) wbad <= wbad + 1;
            run <= 0;
        end
    end

    task automatic complete_run();
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Steering model: JK flip-flop decided when each strobe is routed
    task automatic route();
        logic j, k;
        j = !printer_busy_flag_n || !accessory_graphics_n;
        k = graphics_write_active_n;
        if (j != k) sel = j;
        else if (j) sel = !sel;
        if (sel) exp_aux++;
        else exp_ctl++;
    endtask
    task automatic kbd();
        kbd_req <= 1'b1;
        wt(1);
        kbd_req <= 1'b0;
        route();
        wt(12);
    endtask
    task automatic host();
        host_req <= 1'b1;
        wt(1);
        host_req <= 1'b0;
        route();
        wt(14);
    endtask
    task automatic pulse(input int i);
        p[i] <= 1'b1;
        wt(3);
        p[i] <= 1'b0;
        if (i == 5) sel = 1'b0;
        wt(10);
    endtask
    task automatic takeit();
        lag <= 3'($urandom);
        take <= 1'b1;
        wt(24);
        take <= 1'b0;
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w) begin
            wt(1);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do wt(1); while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do wt(1); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do wt(1); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        complete_run();
    end
    initial begin
        {reset_n, online_select, tab_busy, page_full, erase_interval} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00101;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'hf};
        {kbd_req, host_req, take, lag, p, sel, cs_q, as_q} = '0;
        {power_up_init, link_error_n, glyph_in_progress_n} = 3'h7;
        {graphics_write_active_n, printer_busy_flag_n, accessory_graphics_n} = 3'h7;
        void'($urandom(55851));
        wt(3);
        reset_n <= 1'b1;
        power_up_init <= 1'b0;
        wt(2);
        chk({tx_pending, host_accept_ready, slant_out, large_glyph_n, bright_beam_n,
             text_mode_flag, graphics_flag, double_spacing}, 8'h1c);
        pulse(5);
        kbd();
        chk(tx_pending, 0);
        online_select <= 1'b1;
        wt(8);
        chk(host_accept_ready, 1);
        kbd();
        chk(tx_pending, 1);
        takeit();
        chk(tx_pending, 0);
        for (int i = 0; i < 3; i++) begin
            {tab_busy, page_full, erase_interval} <= 3'b001 << i;
            wt(8);
            chk(host_accept_ready, 0);
            {tab_busy, page_full, erase_interval} <= 3'b000;
            wt(8);
            chk(host_accept_ready, 1);
        end
        foreach (src[i]) begin
            host();
            chk(host_accept_ready, 0);
            pulse(src[i]);
            chk(host_accept_ready, 1);
        end
        axw(4'h0, $urandom | 32'h1, 2'b00);
        axr(4'h0, 32'h1, 2'b00);
        kbd();
        chk({tx_pending, host_accept_ready}, 0);
        pulse(7);
        kbd();
        chk(tx_pending, 1);
        takeit();
        chk(tx_pending, 0);
        axw(4'h0, $urandom & 32'hffff_fffe, 2'b00);
        axw(4'hc, $urandom, 2'b10);
        axr(4'h8, 32'h0, 2'b10);
        pulse(1);
        pulse(0);
        chk(slant_out, 1);
        pulse(2);
        pulse(0);
        chk(slant_out, 0);
        link_error_n <= 1'b0;
        pulse(0);
        chk(slant_out, 1);
        link_error_n <= 1'b1;
        pulse(0);
        chk(slant_out, 0);
        pulse(3);
        chk({large_glyph_n, double_spacing, bright_beam_n}, 3'b011);
        glyph_in_progress_n <= 1'b0;
        wt(8);
        chk(bright_beam_n, 0);
        glyph_in_progress_n <= 1'b1;
        pulse(4);
        chk({text_mode_flag, graphics_flag, bright_beam_n}, 3'b010);
        pulse(2);
        chk(bright_beam_n, 1);
        {graphics_write_active_n, printer_busy_flag_n} <= 2'b00;
        kbd();
        kbd();
        {printer_busy_flag_n, accessory_graphics_n} <= 2'b10;
        kbd();
        chk(n_aux, exp_aux);
        graphics_write_active_n <= 1'b1;
        pulse(5);
        kbd();
        accessory_graphics_n <= 1'b1;
        kbd();
        chk(n_ctl, exp_ctl);
        chk(n_aux, exp_aux);
        chk(wbad, 0);
        complete_run();
    end
endmodule
